/* core/psc_pkg.sv */
// shared constants and types for the power-save clock control block
package psc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the register bus)
    // ------------------------------------------------------------
    localparam int          PSC_AW         = 8;
    localparam logic [7:0]  PSC_OFF_CLOCK_DIVISOR_REG = 8'h00;
    localparam logic [7:0]  PSC_OFF_MODULE_DISABLE_ONE   = 8'h04;
    localparam logic [7:0]  PSC_OFF_RCTL   = 8'h08;
    localparam logic [7:0]  PSC_OFF_STAT   = 8'h0c;

    // ------------------------------------------------------------
    // clock divisor register fields
    // ------------------------------------------------------------
    localparam int          PSC_ROI_BIT     = 15;
    localparam int          PSC_RATIO_LSB   = 12;
    localparam int          PSC_CPU_SLOW_ENABLE_BIT   = 11;
    localparam logic [2:0]  PSC_RATIO_RST   = 3'h0;
    localparam logic [2:0]  PSC_RATIO_ONE   = 3'h0;

    // ------------------------------------------------------------
    // reset control register fields (regulator keep bits)
    // ------------------------------------------------------------
    localparam int          PSC_CORE_KEEP_BIT  = 8;
    localparam int          PSC_FLASH_KEEP_BIT = 11;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int          PSC_ST_SLEEP_BIT = 0;
    localparam int          PSC_ST_IDLE_BIT  = 1;
    localparam int          PSC_ST_HOLD_BIT  = 2;
    localparam int          PSC_ST_DOZE_BIT  = 3;
    localparam int          PSC_ST_SRC_LSB   = 4;

    // ------------------------------------------------------------
    // module disable register one: bit positions
    // ------------------------------------------------------------
    localparam int PSC_TIMER_FIVE_OFF       = 15;
    localparam int PSC_TIMER_FOUR_OFF       = 14;
    localparam int PSC_TIMER_THREE_OFF      = 13;
    localparam int PSC_TIMER_TWO_OFF        = 12;
    localparam int PSC_TIMER_ONE_OFF        = 11;
    localparam int PSC_PULSE_WIDTH_OFF      = 9;
    localparam int PSC_TWO_WIRE_OFF         = 7;
    localparam int PSC_SERIAL_TWO_OFF       = 6;
    localparam int PSC_SERIAL_ONE_OFF       = 5;
    localparam int PSC_SYNC_SERIAL_TWO_OFF  = 4;
    localparam int PSC_SYNC_SERIAL_ONE_OFF  = 3;
    localparam int PSC_CAN_ONE_OFF          = 1;
    localparam int PSC_CONVERTER_ONE_OFF    = 0;
    localparam logic [15:0] PSC_MODULE_DISABLE_ONE_RST    = 16'h0000;
    localparam logic [15:0] PSC_MODULE_DISABLE_ONE_IMPL   =
        16'(32'h1 << PSC_TIMER_FIVE_OFF)      | 16'(32'h1 << PSC_TIMER_FOUR_OFF)   |
        16'(32'h1 << PSC_TIMER_THREE_OFF)     | 16'(32'h1 << PSC_TIMER_TWO_OFF)    |
        16'(32'h1 << PSC_TIMER_ONE_OFF)       | 16'(32'h1 << PSC_PULSE_WIDTH_OFF)  |
        16'(32'h1 << PSC_TWO_WIRE_OFF)        | 16'(32'h1 << PSC_SERIAL_TWO_OFF)   |
        16'(32'h1 << PSC_SERIAL_ONE_OFF)      | 16'(32'h1 << PSC_SYNC_SERIAL_TWO_OFF) |
        16'(32'h1 << PSC_SYNC_SERIAL_ONE_OFF) | 16'(32'h1 << PSC_CAN_ONE_OFF)      |
        16'(32'h1 << PSC_CONVERTER_ONE_OFF);

    // ------------------------------------------------------------
    // power-save instruction operands and wake timing
    // ------------------------------------------------------------
    localparam logic [1:0]  PSC_OP_SLEEP     = 2'h0;
    localparam logic [1:0]  PSC_OP_IDLE      = 2'h1;
    localparam logic [1:0]  PSC_WAKE_CYCLES  = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {PWR_RUN, PWR_ENTER, PWR_SLEEP, PWR_IDLE, PWR_WAKE} psc_pwr_t;

    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [PSC_AW-1:0]   paddr;
        logic [31:0]         pwdata;
    } psc_apb_req_t;

    typedef struct packed {
        psc_pwr_t     pwr;
        logic         to_sleep;
        logic [1:0]   wake_cnt;
        logic [6:0]   doze_cnt;
        logic         return_on_interrupt;
        logic [2:0]   ratio;
        logic         cpu_slow_enable;
        logic [15:0]  pmd;
        logic [15:0]  pmd_eff;
        logic         core_keep;
        logic         flash_keep;
        logic [2:0]   clk_src;
        logic         cpu_clk_en;
        logic         sysclk_run;
        logic         low_power_rc_clock_en;
        logic         wdt_clear;
        logic         clock_failure_monitor_active;
        logic [15:0]  periph_en;
        logic         core_stby;
        logic         flash_stby;
        logic         irq_hold;
        logic         sleeping;
        logic         idling;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } psc_state_t;

endpackage : psc_pkg

/* core/psc_top.sv */
// power-save modes, cpu doze divider and peripheral clock gating
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - sleep operand stops system oscillator and all code execution.
// - idle operand halts cpu; system clock keeps running for peripherals.
// - enabled interrupt, any reset or watchdog time-out leaves sleep or idle.
// - low-power rc clock runs in sleep while watchdog enabled.
// - enabled watchdog is cleared on sleep entry and on idle entry.
// - clock failure monitor inactive during sleep.
// - sleep stops every system-clocked peripheral; external-clocked ones may run.
// - wake from sleep restarts with the clock source selected at entry.
// - regulators go standby in sleep unless their keep bits are set.
// - idle keeps low-power rc clock if watchdog or clock monitor enabled.
// - idle wake reapplies cpu clock, execution resumes two to four cycles later.
// - each peripheral has a bit to stop itself during idle.
// - interrupt during power-save instruction waits until entry completes, then wakes.
// - doze slows only cpu clock; system clock and peripherals stay full speed.
// - doze enable at bit 11, ratio 14:12 selects 1:1 to 1:128.
// - return-on-interrupt bit 15 restores full speed on interrupt; else no effect.
// - hardware clears doze enable on interrupt when return-on-interrupt set.
// - ratio writes ignored while doze enable is set.
// - setting doze enable ignored while ratio is the 1:1 code.
// - module disable bit stops all clocks to that peripheral.
// - peripheral enabled only if bit clear and present; present ones reset enabled.
// - module disable change takes effect one instruction cycle later.
// - register one: timers 15..11, pwm 9, i2c 7, uarts 6,5, spi 4,3, can 1, adc 0.
// - bits 10, 8 and 2 of register one read as zero.
module psc_top #(
    parameter logic [15:0] PRESENT_MASK = psc_pkg::PSC_MODULE_DISABLE_ONE_IMPL
) (
    input  wire logic                        I_CLOCK,
    input  wire logic                        I_RSTN,
    input  wire logic                        I_PSEL,
    input  wire logic                        I_PENABLE,
    input  wire logic                        I_PWRITE,
    input  wire logic [psc_pkg::PSC_AW-1:0]  I_PADDR,
    input  wire logic [31:0]                 I_PWDATA,
    output logic      [31:0]                 O_PRDATA,
    output logic                             O_PREADY,
    output logic                             O_PSLVERR,
    input  wire logic                        I_POWER_SAVE_INSTR_REQ,
    input  wire logic [1:0]                  I_POWER_SAVE_INSTR_OPERAND,
    input  wire logic                        I_IRQ_PENDING,
    input  wire logic                        I_WDT_TIMEOUT,
    input  wire logic                        I_WDT_ENABLED,
    input  wire logic                        I_CLOCK_FAILURE_MONITOR_ENABLED,
    input  wire logic [2:0]                  I_CLK_SRC,
    input  wire logic [15:0]                 I_IDLE_STOP,
    input  wire logic [15:0]                 I_EXT_CLOCKED,
    output logic                             O_CPU_CLK_EN,
    output logic                             O_SYSCLK_RUN,
    output logic                             O_LOW_POWER_RC_CLOCK_EN,
    output logic                             O_WDT_CLEAR,
    output logic                             O_CLOCK_FAILURE_MONITOR_ACTIVE,
    output logic      [15:0]                 O_PERIPH_CLK_EN,
    output logic                             O_CORE_REG_STANDBY,
    output logic                             O_FLASH_REG_STANDBY,
    output logic      [2:0]                  O_WAKE_CLK_SRC,
    output logic                             O_IRQ_HOLD,
    output logic                             O_SLEEPING,
    output logic                             O_IDLING
);
    import psc_pkg::*;

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    psc_state_t   st_ff;
    psc_state_t   nxt_st;
    psc_apb_req_t req;
    logic         wake;
    logic         power_save_instr_take;
    logic         apb_wr;
    logic [6:0]   doze_mask;

    // ratio code n divides the cpu by 2**n
    function automatic logic [6:0] ratio_mask(input logic en, input logic [2:0] r);
        ratio_mask = en ? 7'((8'h01 << r) - 8'h01) : 7'h00;
    endfunction : ratio_mask

    assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                   paddr: I_PADDR, pwdata: I_PWDATA};

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.wdt_clear = 1'b0;
        nxt_st.pready    = 1'b0;
        nxt_st.pslverr   = 1'b0;
        // reset itself wakes the device through the asynchronous clear
        wake        = I_IRQ_PENDING | I_WDT_TIMEOUT;
        // the instruction only executes on a cpu clock tick
        power_save_instr_take = I_POWER_SAVE_INSTR_REQ && (st_ff.pwr == PWR_RUN) && st_ff.cpu_clk_en &&
                      ((I_POWER_SAVE_INSTR_OPERAND == PSC_OP_SLEEP) ||
                       (I_POWER_SAVE_INSTR_OPERAND == PSC_OP_IDLE));
        apb_wr      = req.psel && req.penable && st_ff.pready && req.pwrite;

        // ------------------------------------------------------------
        // register bus: answer one cycle into the access phase
        // ------------------------------------------------------------
        if (req.psel && req.penable && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = 32'h0000_0000;
            case (req.paddr)
                PSC_OFF_CLOCK_DIVISOR_REG: begin
                    nxt_st.prdata[PSC_ROI_BIT]                  = st_ff.return_on_interrupt;
                    nxt_st.prdata[PSC_RATIO_LSB +: 3]           = st_ff.ratio;
                    nxt_st.prdata[PSC_CPU_SLOW_ENABLE_BIT]                = st_ff.cpu_slow_enable;
                end
                PSC_OFF_MODULE_DISABLE_ONE: begin
                    nxt_st.prdata[15:0] = st_ff.pmd;
                end
                PSC_OFF_RCTL: begin
                    nxt_st.prdata[PSC_CORE_KEEP_BIT]  = st_ff.core_keep;
                    nxt_st.prdata[PSC_FLASH_KEEP_BIT] = st_ff.flash_keep;
                end
                PSC_OFF_STAT: begin
                    nxt_st.prdata[PSC_ST_SLEEP_BIT]    = st_ff.sleeping;
                    nxt_st.prdata[PSC_ST_IDLE_BIT]     = st_ff.idling;
                    nxt_st.prdata[PSC_ST_HOLD_BIT]     = st_ff.irq_hold;
                    nxt_st.prdata[PSC_ST_DOZE_BIT]     = st_ff.cpu_slow_enable;
                    nxt_st.prdata[PSC_ST_SRC_LSB +: 3] = st_ff.clk_src;
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // writes land at the edge where pready is sampled high
        if (apb_wr) begin
            case (req.paddr)
                PSC_OFF_CLOCK_DIVISOR_REG: begin
                    nxt_st.return_on_interrupt = req.pwdata[PSC_ROI_BIT];
                    if (!st_ff.cpu_slow_enable) begin
                        nxt_st.ratio = req.pwdata[PSC_RATIO_LSB +: 3];
                    end
                    // set refused at 1:1; the ratio written in the same access counts
                    if (!req.pwdata[PSC_CPU_SLOW_ENABLE_BIT] || (nxt_st.ratio != PSC_RATIO_ONE)) begin
                        nxt_st.cpu_slow_enable = req.pwdata[PSC_CPU_SLOW_ENABLE_BIT];
                    end
                end
                PSC_OFF_MODULE_DISABLE_ONE: begin
                    nxt_st.pmd = req.pwdata[15:0] & PSC_MODULE_DISABLE_ONE_IMPL;
                end
                PSC_OFF_RCTL: begin
                    nxt_st.core_keep  = req.pwdata[PSC_CORE_KEEP_BIT];
                    nxt_st.flash_keep = req.pwdata[PSC_FLASH_KEEP_BIT];
                end
                default: begin
                    nxt_st.pmd = nxt_st.pmd;
                end
            endcase
        end

        // hardware clear beats a software write in the same cycle
        if (st_ff.return_on_interrupt && st_ff.cpu_slow_enable && I_IRQ_PENDING) begin
            nxt_st.cpu_slow_enable = 1'b0;
        end

        // ------------------------------------------------------------
        // power-save sequencing
        // ------------------------------------------------------------
        case (st_ff.pwr)
            PWR_RUN: begin
                if (power_save_instr_take) begin
                    nxt_st.pwr       = PWR_ENTER;
                    nxt_st.to_sleep  = (I_POWER_SAVE_INSTR_OPERAND == PSC_OP_SLEEP);
                    nxt_st.clk_src   = I_CLK_SRC;
                    nxt_st.wdt_clear = I_WDT_ENABLED;
                end
            end
            PWR_ENTER: begin
                // interrupts wait here until the low-power state is reached
                nxt_st.pwr = st_ff.to_sleep ? PWR_SLEEP : PWR_IDLE;
            end
            PWR_SLEEP, PWR_IDLE: begin
                if (wake) begin
                    nxt_st.pwr      = PWR_WAKE;
                    nxt_st.wake_cnt = PSC_WAKE_CYCLES - 2'h1;
                end
            end
            PWR_WAKE: begin
                if (st_ff.wake_cnt == 2'h0) begin
                    nxt_st.pwr = PWR_RUN;
                end else begin
                    nxt_st.wake_cnt = st_ff.wake_cnt - 2'h1;
                end
            end
            default: begin
                nxt_st.pwr = PWR_RUN;
            end
        endcase

        // ------------------------------------------------------------
        // doze divider: only the cpu tick is thinned out
        // ------------------------------------------------------------
        nxt_st.doze_cnt   = (st_ff.pwr == PWR_RUN) ? 7'(st_ff.doze_cnt + 7'h01) : 7'h00;
        doze_mask         = ratio_mask(nxt_st.cpu_slow_enable, nxt_st.ratio);
        nxt_st.cpu_clk_en = (nxt_st.pwr == PWR_RUN) &&
                            ((nxt_st.doze_cnt & doze_mask) == 7'h00);

        // one instruction cycle of latency on module disable changes
        if (st_ff.cpu_clk_en) begin
            nxt_st.pmd_eff = st_ff.pmd;
        end

        // ------------------------------------------------------------
        // clock and power outputs, all from the next state
        // ------------------------------------------------------------
        nxt_st.sleeping    = (nxt_st.pwr == PWR_SLEEP);
        nxt_st.idling      = (nxt_st.pwr == PWR_IDLE);
        nxt_st.irq_hold    = (nxt_st.pwr == PWR_ENTER);
        // oscillator restarts as soon as the wake begins
        nxt_st.sysclk_run  = !nxt_st.sleeping;
        nxt_st.low_power_rc_clock_en     = I_WDT_ENABLED || (!nxt_st.sleeping && I_CLOCK_FAILURE_MONITOR_ENABLED);
        nxt_st.clock_failure_monitor_active = I_CLOCK_FAILURE_MONITOR_ENABLED && !nxt_st.sleeping;
        nxt_st.core_stby   = nxt_st.sleeping && !st_ff.core_keep;
        nxt_st.flash_stby  = nxt_st.sleeping && !st_ff.flash_keep;
        nxt_st.periph_en   = PRESENT_MASK & ~nxt_st.pmd_eff;
        if (nxt_st.sleeping) begin
            nxt_st.periph_en = nxt_st.periph_en & I_EXT_CLOCKED;
        end else if (nxt_st.idling) begin
            nxt_st.periph_en = nxt_st.periph_en & ~I_IDLE_STOP;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_ff            <= '0;
            st_ff.pwr        <= PWR_RUN;
            st_ff.ratio      <= PSC_RATIO_RST;
            st_ff.pmd        <= PSC_MODULE_DISABLE_ONE_RST;
            st_ff.pmd_eff    <= PSC_MODULE_DISABLE_ONE_RST;
            st_ff.sysclk_run <= 1'b1;
            st_ff.periph_en  <= PRESENT_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_PRDATA            = st_ff.prdata;
    assign O_PREADY            = st_ff.pready;
    assign O_PSLVERR           = st_ff.pslverr;
    assign O_CPU_CLK_EN        = st_ff.cpu_clk_en;
    assign O_SYSCLK_RUN        = st_ff.sysclk_run;
    assign O_LOW_POWER_RC_CLOCK_EN           = st_ff.low_power_rc_clock_en;
    assign O_WDT_CLEAR         = st_ff.wdt_clear;
    assign O_CLOCK_FAILURE_MONITOR_ACTIVE       = st_ff.clock_failure_monitor_active;
    assign O_PERIPH_CLK_EN     = st_ff.periph_en;
    assign O_CORE_REG_STANDBY  = st_ff.core_stby;
    assign O_FLASH_REG_STANDBY = st_ff.flash_stby;
    assign O_WAKE_CLK_SRC      = st_ff.clk_src;
    assign O_IRQ_HOLD          = st_ff.irq_hold;
    assign O_SLEEPING          = st_ff.sleeping;
    assign O_IDLING            = st_ff.idling;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);

    sleep_osc_off_a: assert property (O_SLEEPING |-> !O_SYSCLK_RUN && !O_CPU_CLK_EN)
        else $error("oscillator or cpu running in sleep");
    idle_cpu_stop_a: assert property (O_IDLING |-> O_SYSCLK_RUN && !O_CPU_CLK_EN)
        else $error("idle state clocks wrong");
    wake_exit_a: assert property ((O_SLEEPING || O_IDLING) && (I_IRQ_PENDING || I_WDT_TIMEOUT)
        |=> !O_SLEEPING && !O_IDLING)
        else $error("wake event did not leave low-power state");
    sleep_low_power_rc_clock_a: assert property (O_SLEEPING && $past(I_WDT_ENABLED) |-> O_LOW_POWER_RC_CLOCK_EN)
        else $error("rc clock off in sleep with watchdog on");
    entry_wdt_clear_a: assert property (power_save_instr_take && I_WDT_ENABLED
        |=> O_WDT_CLEAR ##1 !O_WDT_CLEAR)
        else $error("watchdog not cleared once on entry");
    clock_failure_monitor_off_a: assert property (O_SLEEPING |-> !O_CLOCK_FAILURE_MONITOR_ACTIVE)
        else $error("clock monitor active in sleep");
    sleep_periph_a: assert property (O_SLEEPING |->
        (O_PERIPH_CLK_EN & ~$past(I_EXT_CLOCKED)) == 16'h0000)
        else $error("system-clocked peripheral running in sleep");
    wake_src_a: assert property (power_save_instr_take |=> O_WAKE_CLK_SRC == $past(I_CLK_SRC))
        else $error("clock source not captured at entry");
    regulator_a: assert property (O_SLEEPING |-> O_CORE_REG_STANDBY == !$past(st_ff.core_keep))
        else $error("core regulator standby wrong in sleep");
    idle_wake_time_a: assert property (O_IDLING && I_IRQ_PENDING
        |-> ##1 !O_CPU_CLK_EN ##1 !O_CPU_CLK_EN ##1 O_CPU_CLK_EN)
        else $error("cpu did not resume three cycles after idle wake");
    irq_defer_a: assert property (O_IRQ_HOLD |=> O_SLEEPING || O_IDLING)
        else $error("entry not completed after hold");
    roi_clear_a: assert property (st_ff.return_on_interrupt && st_ff.cpu_slow_enable && I_IRQ_PENDING
        |=> !st_ff.cpu_slow_enable)
        else $error("doze enable not cleared on interrupt");
    ratio_lock_a: assert property (st_ff.cpu_slow_enable && apb_wr && req.paddr == PSC_OFF_CLOCK_DIVISOR_REG
        |=> $stable(st_ff.ratio))
        else $error("ratio changed while doze enabled");
    cpu_slow_enable_one_a: assert property (st_ff.ratio == PSC_RATIO_ONE |-> !st_ff.cpu_slow_enable)
        else $error("doze enabled at 1:1");

    sleep_entry_c: cover property (power_save_instr_take ##2 O_SLEEPING);
    idle_wake_c:   cover property (O_IDLING ##1 !O_IDLING ##[1:4] O_CPU_CLK_EN);
    doze_tick_c:   cover property (st_ff.cpu_slow_enable && O_CPU_CLK_EN ##1 !O_CPU_CLK_EN);
    roi_clear_c:   cover property (st_ff.cpu_slow_enable ##1 !st_ff.cpu_slow_enable);

endmodule : psc_top

/* testbench/psc_cpu_model.sv */
// cpu-side model that issues the power-save instruction
`timescale 1ns/1ps
module psc_cpu_model (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_go,
    input  wire logic [1:0] i_op,
    input  wire logic       i_cpu_tick,
    output logic            o_req,
    output logic      [1:0] o_operand
);
    // the instruction stays up until a cpu tick retires it, as in doze
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_req     <= 1'h0;
            o_operand <= 2'h3;
        end else if (o_req && i_cpu_tick) begin
            o_req     <= 1'h0;
            o_operand <= ~o_operand; // released: never keep the last code
        end else if (i_go) begin
            o_req     <= 1'h1;
            o_operand <= i_op;
        end
    end
endmodule : psc_cpu_model

/* testbench/tb_top.sv */
// self-checking bench for the power-save clock control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import psc_pkg::*;
    logic        clk, rstn, psel, pen, pwr, go, irq, wto, wdt_en, clock_failure_monitor_en, prdy, perr, serr;
    logic        cpu, sysrun, low_power_rc_clock, wclr, clock_failure_monitor, cstb, fstb, hold, slp, idl, sv_req;
    logic [7:0]  padr;
    logic [31:0] pwd, prd, rdat;
    logic [1:0]  op, sv_op;
    logic [2:0]  src, wsrc;
    logic [15:0] istop, ext, pclk, sd, v;
    int          fails, num_checks, n;

    psc_top psc_top_i (.I_CLOCK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
        .O_PSLVERR(perr), .I_POWER_SAVE_INSTR_REQ(sv_req), .I_POWER_SAVE_INSTR_OPERAND(sv_op), .I_IRQ_PENDING(irq),
        .I_WDT_TIMEOUT(wto), .I_WDT_ENABLED(wdt_en), .I_CLOCK_FAILURE_MONITOR_ENABLED(clock_failure_monitor_en), .I_CLK_SRC(src),
        .I_IDLE_STOP(istop), .I_EXT_CLOCKED(ext), .O_CPU_CLK_EN(cpu), .O_SYSCLK_RUN(sysrun),
        .O_LOW_POWER_RC_CLOCK_EN(low_power_rc_clock), .O_WDT_CLEAR(wclr), .O_CLOCK_FAILURE_MONITOR_ACTIVE(clock_failure_monitor), .O_PERIPH_CLK_EN(pclk),
        .O_CORE_REG_STANDBY(cstb), .O_FLASH_REG_STANDBY(fstb), .O_WAKE_CLK_SRC(wsrc),
        .O_IRQ_HOLD(hold), .O_SLEEPING(slp), .O_IDLING(idl));
    psc_cpu_model psc_cpu_model_i (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_op(op),
        .i_cpu_tick(cpu), .o_req(sv_req), .o_operand(sv_op));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] exp_pclk(input logic idle, input logic [15:0] st, ex);
        return PSC_MODULE_DISABLE_ONE_IMPL & (idle ? ~st : ex);
    endfunction : exp_pclk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'h1; pen <= 1'h0; pwr <= w; padr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        i = 0;
        do begin @(posedge clk); i++; end while (prdy !== 1'h1 && i < 50);
        rdat = prd;
        serr = perr;
        psel <= 1'h0; pen <= 1'h0;
    endtask : apb
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #200000;
        fails++;
        test_done();
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        {psel, pen, pwr, go, irq, wto, wdt_en, clock_failure_monitor_en, rstn} = '0;
        padr = '0; pwd = '0; op = '0; src = '0; istop = '0; ext = '0;
        fails = 0; num_checks = 0; sd = 16'h002c;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk); #1;
        `CHK("periph clocks", PSC_MODULE_DISABLE_ONE_IMPL, pclk)
        apb(1'h0, 8'h40, 32'h0);
        `CHK("slave error", 1'h1, serr)
        for (int i = 0; i < 5; i++) begin
            sd = lfsr(sd);
            v = (i == 0) ? 16'hffff : sd;
            apb(1'h1, PSC_OFF_MODULE_DISABLE_ONE, {16'h0, v});
            repeat (3) @(posedge clk); #1;
            `CHK("periph clocks", PSC_MODULE_DISABLE_ONE_IMPL & ~v, pclk)
            apb(1'h0, PSC_OFF_MODULE_DISABLE_ONE, 32'h0);
            `CHK("disable reg", {16'h0, v & PSC_MODULE_DISABLE_ONE_IMPL}, rdat)
        end
        apb(1'h1, PSC_OFF_MODULE_DISABLE_ONE, 32'h0);
        $display("test module disable done");
        apb(1'h1, PSC_OFF_CLOCK_DIVISOR_REG, 32'h0800);
        apb(1'h0, PSC_OFF_CLOCK_DIVISOR_REG, 32'h0);
        `CHK("doze enable", 1'h0, rdat[PSC_CPU_SLOW_ENABLE_BIT])
        for (int r = 1; r < 8; r++) begin
            apb(1'h1, PSC_OFF_CLOCK_DIVISOR_REG, 32'h0);
            apb(1'h1, PSC_OFF_CLOCK_DIVISOR_REG, (32'(r) << 12) | 32'h0800);
            repeat (2) @(posedge clk);
            n = 0;
            repeat (128) begin @(posedge clk); #1; n += int'(cpu); end
            `CHK("cpu ticks", 128 >> r, n)
            `CHK("system clock", 1'h1, sysrun)
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'h1, PSC_OFF_CLOCK_DIVISOR_REG, k ? 32'hf800 : 32'h2800);
            @(posedge clk) irq <= 1'h1;
            @(posedge clk) irq <= 1'h0;
            apb(1'h0, PSC_OFF_CLOCK_DIVISOR_REG, 32'h0);
            `CHK("clock divisor", k ? 32'hf000 : 32'h7800, rdat)
        end
        `CHK("cpu full speed", 1'h1, cpu)
        apb(1'h1, PSC_OFF_CLOCK_DIVISOR_REG, 32'h0);
        $display("test doze done");
        for (int k = 0; k < 4; k++) begin
            sd = lfsr(sd);
            @(posedge clk);
            op <= {1'h0, k[0]}; src <= sd[2:0]; wdt_en <= sd[3]; clock_failure_monitor_en <= sd[4];
            istop <= lfsr(sd); ext <= ~sd;
            apb(1'h1, PSC_OFF_RCTL, k[1] ? 32'h0900 : 32'h0);
            @(posedge clk) go <= 1'h1;
            @(posedge clk) go <= 1'h0;
            n = 0;
            do begin @(posedge clk); #1; n++; end while (hold !== 1'h1 && n < 20);
            `CHK("watchdog clear", wdt_en, wclr)
            @(posedge clk); #1;
            `CHK("sleeping", ~k[0], slp)
            `CHK("idling", k[0], idl)
            `CHK("system clock", k[0], sysrun)
            `CHK("cpu clock", 1'h0, cpu)
            `CHK("clock monitor", k[0] & clock_failure_monitor_en, clock_failure_monitor)
            `CHK("low power rc", wdt_en | (k[0] & clock_failure_monitor_en), low_power_rc_clock)
            `CHK("core standby", ~k[0] & ~k[1], cstb)
            `CHK("flash standby", ~k[0] & ~k[1], fstb)
            `CHK("periph clocks", exp_pclk(k[0], istop, ext), pclk)
            apb(1'h0, PSC_OFF_STAT, 32'h0);
            `CHK("status", {25'h0, src, 2'h0, k[0], ~k[0]}, rdat)
            @(posedge clk);
            if (k[0]) irq <= 1'h1;
            else wto <= 1'h1;
            n = 0;
            do begin @(posedge clk); #1; n++; end while (cpu !== 1'h1 && n < 10);
            `CHK("wake delay", 1'h1, n >= 2 && n <= 4)
            `CHK("wake source", src, wsrc)
            @(posedge clk);
            irq <= 1'h0; wto <= 1'h0;
            $display("test power mode %0d done", k);
        end
        test_done();
    end
endmodule : tb_top
